// ---- include/host_if_defs.svh ----
// timing and layout constants for the host interface mode select block
// assumes inclusion by bare name from design files only
`ifndef HOST_IF_DEFS_SVH
`define HOST_IF_DEFS_SVH

// serial word assembled from the link
`define HIF_WORD_BITS    24
// bits in one two-wire byte, acknowledge excluded
`define HIF_BYTE_BITS    8
// bytes that make up one two-wire word
`define HIF_WORD_BYTES   3
// edges after reset before the power-up strap sample; the synchroniser
// output only holds the real pin level from the second edge on
`define HIF_STRAP_WAIT   2'h3
// fastest serial clock in shift mode, in MHz
`define HIF_SPI_MAX_MHZ  50
// two-wire rates in kHz
`define HIF_I2C_STD_KHZ  100
`define HIF_I2C_FAST_KHZ 400

`endif

// ---- include/host_if_pkg.sv ----
// types shared by the host interface mode select block
// assumes host_if_defs.svh is compiled alongside
package host_if_pkg;

    // interface mode, gray coded
    typedef enum logic [1:0] {
        MODE_PAR = 2'h0,
        MODE_SPI = 2'h1,
        MODE_I2C = 2'h3
    } host_mode_t;

    // synchronised static pins
    typedef struct packed {
        logic power_down;
        logic serial_parallel_select;
        logic mode_pin;
        logic fifo_strap;
        logic load_cfg;
    } pin_set_t;

    // power state shown to the analog side
    typedef struct packed {
        logic low_power;
        logic out_hiz;
        logic out_gnd_load;
    } power_state_t;

endpackage : host_if_pkg

// ---- core/host_if_sync.sv ----
// two flip-flop level synchroniser, one per bit
// assumes the destination clock and an active-low async reset
`timescale 1ns/1ps

module host_if_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);

    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] q_r;

    // first stage feeds only the second
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_r <= '0;
            q_r    <= '0;
        end else begin
            meta_r <= d_i;
            q_r    <= meta_r;
        end
    end

    assign q_o = q_r;

endmodule : host_if_sync

// ---- core/host_if_link.sv ----
// serial clock domain: shift-mode and two-wire bit capture, readback drive
// assumes link_clk_i is the serial clock pin and may stop between frames
`timescale 1ns/1ps
`include "host_if_defs.svh"

module host_if_link #(
    parameter int WORD_BITS = `HIF_WORD_BITS
) (
    input  wire logic                 link_clk_i,
    input  wire logic                 rst_n_i,
    input  wire logic                 ser_i,
    input  wire logic                 two_wire_i,
    input  wire logic                 din_i,
    input  wire logic [WORD_BITS-1:0] rb_word_i,
    output logic      [WORD_BITS-1:0] word_o,
    output logic                      word_tgl_o,
    output logic                      sdo_o,
    output logic                      sdo_oe_n_o,
    output logic                      sda_out_o,
    output logic                      sda_oe_n_o
);

    localparam int CW = $clog2(WORD_BITS + 1);

    logic [1:0]           mode_s;
    logic [WORD_BITS-1:0] sh_r, sh_nxt, word_r, word_nxt;
    logic [CW-1:0]        cnt_r, cnt_nxt;
    logic [3:0]           bit_r, bit_nxt;
    logic                 tgl_r, tgl_nxt, ack_r, ack_nxt;
    logic                 sda_samp_r, sdo_r, sdo_en_r;
    logic [WORD_BITS-1:0] rb_r;

    // mode pins are static; resample them on the serial clock
    host_if_sync #(.WIDTH(2)) u_mode_sync (
        .clk_i   (link_clk_i),
        .rst_n_i (rst_n_i),
        .d_i     ({ser_i, two_wire_i}),
        .q_o     (mode_s)
    );

    // falling edge: shift data in, count bits, hand off whole words
    always_comb begin
        sh_nxt   = sh_r;
        cnt_nxt  = cnt_r;
        bit_nxt  = bit_r;
        word_nxt = word_r;
        tgl_nxt  = tgl_r;
        ack_nxt  = 1'b0;
        if (mode_s[1] && !mode_s[0]) begin
            sh_nxt  = {sh_r[WORD_BITS-2:0], din_i};
            cnt_nxt = cnt_r + 1'b1;
        end else if (mode_s[1]) begin
            if (bit_r == 4'(`HIF_BYTE_BITS)) begin
                bit_nxt = 4'h0;
            end else begin
                sh_nxt  = {sh_r[WORD_BITS-2:0], sda_samp_r};
                bit_nxt = bit_r + 4'h1;
                cnt_nxt = cnt_r + 1'b1;
                ack_nxt = (bit_r == 4'(`HIF_BYTE_BITS - 1));
            end
        end
        if (cnt_nxt == CW'(WORD_BITS)) begin
            word_nxt = sh_nxt;
            tgl_nxt  = ~tgl_r;
            cnt_nxt  = '0;
        end
    end

    always_ff @(negedge link_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sh_r   <= '0;
            cnt_r  <= '0;
            bit_r  <= 4'h0;
            word_r <= '0;
            tgl_r  <= 1'b0;
            ack_r  <= 1'b0;
        end else begin
            sh_r   <= sh_nxt;
            cnt_r  <= cnt_nxt;
            bit_r  <= bit_nxt;
            word_r <= word_nxt;
            tgl_r  <= tgl_nxt;
            ack_r  <= ack_nxt;
        end
    end

    // rising edge: sample sda, drive readback out
    always_ff @(posedge link_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sda_samp_r <= 1'b0;
            sdo_r      <= 1'b0;
            sdo_en_r   <= 1'b0;
            rb_r       <= '0;
        end else begin
            sda_samp_r <= din_i;
            sdo_en_r   <= mode_s[1] && !mode_s[0];
            if (cnt_r == '0) begin
                rb_r  <= {rb_word_i[WORD_BITS-2:0], 1'b0};
                sdo_r <= rb_word_i[WORD_BITS-1];
            end else begin
                rb_r  <= {rb_r[WORD_BITS-2:0], 1'b0};
                sdo_r <= rb_r[WORD_BITS-1];
            end
        end
    end

    assign word_o     = word_r;
    assign word_tgl_o = tgl_r;
    assign sdo_o      = sdo_r;
    assign sdo_oe_n_o = ~sdo_en_r;
    assign sda_out_o  = 1'b0;       // open drain only pulls low
    assign sda_oe_n_o = ~ack_r;

    // open drain never drives high and only pulls in the acknowledge slot
    a_sda_open_drain: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
        !sda_oe_n_o |-> !sda_out_o && bit_r == 4'(`HIF_BYTE_BITS))
        else $error("sda driven high or outside acknowledge");
    // word count never passes the word size
    a_link_count: assert property (@(negedge link_clk_i) disable iff (!rst_n_i)
        cnt_r < CW'(WORD_BITS)) else $error("bit count overflow");

endmodule : host_if_link

// ---- core/host_interface_mode_select.sv ----
// host pin and mode logic: mode decode, pin reuse, power-down, fifo strap
// assumes pins are asynchronous to clk_i and link_clk_i is the serial clock
`timescale 1ns/1ps
`include "host_if_defs.svh"

module host_interface_mode_select #(
    parameter int WORD_BITS = `HIF_WORD_BITS
) (
    input  wire logic                 clk_i,
    input  wire logic                 rst_n_i,
    input  wire logic                 data_bit_twelve_clock_pin_i,
    input  wire logic                 power_down_input_i,
    input  wire logic                 serial_parallel_select_i,
    input  wire logic                 data_bit_nine_mode_pin_i,
    input  wire logic                 data_bit_ten_clock_pin_i,
    input  wire logic                 data_bit_eleven_data_pin_i,
    input  wire logic                 fifo_enable_strap_i,
    input  wire logic                 pd_ground_load_i,
    input  wire logic                 clear_n_i,
    input  wire logic                 hw_reset_n_i,
    input  wire logic [WORD_BITS-1:0] readback_word_i,
    output host_if_pkg::host_mode_t   mode_o,
    output logic                      fifo_active_o,
    output logic                      analog_low_power_o,
    output logic                      output_hiz_o,
    output logic                      output_gnd_load_o,
    output logic [2:0]                parallel_high_bits_o,
    output logic [WORD_BITS-1:0]      serial_word_o,
    output logic                      serial_word_valid_o,
    output logic                      serial_readback_output_o,
    output logic                      serial_readback_oe_n_o,
    output logic                      sda_out_o,
    output logic                      sda_oe_n_o
);

    host_if_pkg::pin_set_t     pins_raw;
    host_if_pkg::pin_set_t     pins_s;
    host_if_pkg::power_state_t pwr_r;
    host_if_pkg::power_state_t pwr_nxt;
    host_if_pkg::host_mode_t   mode_r;
    host_if_pkg::host_mode_t   mode_nxt;

    logic [2:0]           pbits_raw;
    logic [2:0]           pbits_s;
    logic [1:0]           evt_s;
    logic [1:0]           evt_prev_r;
    logic                 evt_fall;
    logic                 tgl_s;
    logic                 tgl_prev_r;
    logic                 word_edge;

    logic                 strap_lat_r;
    logic                 strap_lat_nxt;
    logic [1:0]           strap_wait_r;
    logic [1:0]           strap_wait_nxt;
    logic                 fifo_r;
    logic                 fifo_nxt;
    logic [2:0]           pbits_r;
    logic [2:0]           pbits_nxt;
    logic [WORD_BITS-1:0] word_r;
    logic [WORD_BITS-1:0] word_nxt;
    logic                 valid_r;
    logic                 valid_nxt;

    logic [WORD_BITS-1:0] link_word;
    logic                 link_tgl;
    logic                 ser_mode;
    logic                 two_wire;

    // gather static pins into one group
    always_comb begin
        pins_raw.power_down = power_down_input_i;
        pins_raw.serial_parallel_select    = serial_parallel_select_i;
        pins_raw.mode_pin   = data_bit_nine_mode_pin_i;
        pins_raw.fifo_strap = fifo_enable_strap_i;
        pins_raw.load_cfg   = pd_ground_load_i;
    end

    assign pbits_raw = {data_bit_eleven_data_pin_i,
                        data_bit_ten_clock_pin_i,
                        data_bit_nine_mode_pin_i};

    // every static pin passes two flip-flops before use; the link takes the clock and data pins raw
    host_if_sync #(.WIDTH($bits(host_if_pkg::pin_set_t))) u_pin_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .d_i     (pins_raw),
        .q_o     (pins_s)
    );

    host_if_sync #(.WIDTH(3)) u_pbit_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .d_i     (pbits_raw),
        .q_o     (pbits_s)
    );

    host_if_sync #(.WIDTH(2)) u_evt_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .d_i     ({clear_n_i, hw_reset_n_i}),
        .q_o     (evt_s)
    );

    host_if_sync #(.WIDTH(1)) u_tgl_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .d_i     (link_tgl),
        .q_o     (tgl_s)
    );

    // clear and reset act on their falling edges
    assign evt_fall  = |(evt_prev_r & ~evt_s);
    // a new word from the link shows as a toggle change
    assign word_edge = tgl_s ^ tgl_prev_r;

    // serial clock side: shift mode and two-wire capture
    assign ser_mode = pins_raw.serial_parallel_select;
    assign two_wire = pins_raw.mode_pin;

    host_if_link #(.WORD_BITS(WORD_BITS)) u_link (
        .link_clk_i (data_bit_twelve_clock_pin_i),
        .rst_n_i    (rst_n_i),
        .ser_i      (ser_mode),
        .two_wire_i (two_wire),
        .din_i      (data_bit_eleven_data_pin_i),
        .rb_word_i  (readback_word_i),
        .word_o     (link_word),
        .word_tgl_o (link_tgl),
        .sdo_o      (serial_readback_output_o),
        .sdo_oe_n_o (serial_readback_oe_n_o),
        .sda_out_o  (sda_out_o),
        .sda_oe_n_o (sda_oe_n_o)
    );

    // mode decode from the serial select and the mode pin
    always_comb begin
        mode_nxt = host_if_pkg::MODE_PAR;
        case ({pins_s.serial_parallel_select, pins_s.mode_pin})
            2'h2:    mode_nxt = host_if_pkg::MODE_SPI;
            2'h3:    mode_nxt = host_if_pkg::MODE_I2C;
            default: mode_nxt = host_if_pkg::MODE_PAR;
        endcase
    end

    // power-down state toward the analog side
    always_comb begin
        pwr_nxt.low_power    = pins_s.power_down;
        pwr_nxt.out_hiz      = pins_s.power_down && !pins_s.load_cfg;
        pwr_nxt.out_gnd_load = pins_s.power_down && pins_s.load_cfg;
    end

    // strap sampling, fifo enable and parallel high bits
    always_comb begin
        strap_wait_nxt = strap_wait_r;
        strap_lat_nxt  = strap_lat_r;
        // count down to the first sample, once the synchroniser holds the pin
        if (strap_wait_r != 2'h0) begin
            strap_wait_nxt = strap_wait_r - 2'h1;
            if (strap_wait_r == 2'h1) begin
                strap_lat_nxt = pins_s.fifo_strap;
            end
        end else if (evt_fall) begin
            strap_lat_nxt = pins_s.fifo_strap;
        end
        // a strap left high in serial modes is simply ignored here
        fifo_nxt  = strap_lat_nxt && (mode_nxt == host_if_pkg::MODE_PAR);
        pbits_nxt = (mode_nxt == host_if_pkg::MODE_PAR) ? pbits_s : 3'h0;
    end

    // serial word hand-off, independent of power-down
    always_comb begin
        word_nxt  = word_r;
        valid_nxt = 1'b0;
        if (word_edge && mode_r != host_if_pkg::MODE_PAR) begin
            word_nxt  = link_word;
            valid_nxt = 1'b1;
        end
    end

    // register all system clock state
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mode_r       <= host_if_pkg::MODE_PAR;
            pwr_r        <= '0;
            strap_wait_r <= `HIF_STRAP_WAIT;
            strap_lat_r  <= 1'b0;
            fifo_r       <= 1'b0;
            pbits_r      <= 3'h0;
            word_r       <= '0;
            valid_r      <= 1'b0;
            evt_prev_r   <= 2'h0;
            tgl_prev_r   <= 1'b0;
        end else begin
            mode_r       <= mode_nxt;
            pwr_r        <= pwr_nxt;
            strap_wait_r <= strap_wait_nxt;
            strap_lat_r  <= strap_lat_nxt;
            fifo_r       <= fifo_nxt;
            pbits_r      <= pbits_nxt;
            word_r       <= word_nxt;
            valid_r      <= valid_nxt;
            evt_prev_r   <= evt_s;
            tgl_prev_r   <= tgl_s;
        end
    end

    // outputs straight from flip-flops
    assign mode_o               = mode_r;
    assign fifo_active_o        = fifo_r;
    assign analog_low_power_o   = pwr_r.low_power;
    assign output_hiz_o         = pwr_r.out_hiz;
    assign output_gnd_load_o    = pwr_r.out_gnd_load;
    assign parallel_high_bits_o = pbits_r;
    assign serial_word_o        = word_r;
    assign serial_word_valid_o  = valid_r;

    // checks on the system clock
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    // two steady cycles of the synchronised select pins
    sequence s_static_spi;
        (pins_s.serial_parallel_select && !pins_s.mode_pin) [*2];
    endsequence

    sequence s_static_i2c;
        (pins_s.serial_parallel_select && pins_s.mode_pin) [*2];
    endsequence

    // a word pulse stands for exactly one cycle
    sequence s_word_pulse;
        serial_word_valid_o ##1 !serial_word_valid_o;
    endsequence

    a_fifo_par_only: assert property (
        fifo_active_o |-> mode_o == host_if_pkg::MODE_PAR && strap_lat_r)
        else $error("fifo active outside parallel mode");
    a_strap_relatch: assert property (
        strap_wait_r == 2'h0 && evt_fall |=> strap_lat_r == $past(pins_s.fifo_strap))
        else $error("strap not relatched on event");
    a_strap_powerup: assert property (
        strap_wait_r == 2'h1 |=> strap_lat_r == $past(pins_s.fifo_strap) && strap_wait_r == 2'h0)
        else $error("strap not latched at power-up");
    a_pd_low_power: assert property (
        pins_s.power_down |=> analog_low_power_o && (output_hiz_o != output_gnd_load_o))
        else $error("power-down not applied");
    a_pd_release: assert property (
        !pins_s.power_down |=> !analog_low_power_o && !output_hiz_o && !output_gnd_load_o)
        else $error("power-down state stuck");
    a_mode_spi_pick: assert property (
        s_static_spi |=> mode_o == host_if_pkg::MODE_SPI)
        else $error("shift mode not selected");
    a_mode_i2c_pick: assert property (
        s_static_i2c |=> mode_o == host_if_pkg::MODE_I2C)
        else $error("two-wire mode not selected");
    a_par_high_bits: assert property (
        !pins_s.serial_parallel_select |=> parallel_high_bits_o == $past(pbits_s))
        else $error("parallel high bits wrong");
    a_word_in_pd: assert property (
        word_edge && mode_r != host_if_pkg::MODE_PAR |=> s_word_pulse)
        else $error("serial word dropped or stretched");

    // fifo stays off in both serial modes
    a_fifo_serial_off: assert property (
        mode_o != host_if_pkg::MODE_PAR |-> !fifo_active_o)
        else $error("fifo active in serial mode");
    // strap changes between events are ignored
    a_strap_hold: assert property (
        strap_wait_r == 2'h0 && !evt_fall |=> $stable(strap_lat_r))
        else $error("strap latch moved without event");
    // shared pins carry no data bits in serial modes
    a_serial_bits_zero: assert property (
        pins_s.serial_parallel_select |=> parallel_high_bits_o == 3'h0)
        else $error("parallel bits shown in serial mode");
    // serial select low always means parallel mode
    a_mode_par_pick: assert property (
        !pins_s.serial_parallel_select |=> mode_o == host_if_pkg::MODE_PAR)
        else $error("parallel mode not selected");
    // the handed-off word is the one the link finished
    a_word_data: assert property (
        word_edge && mode_r != host_if_pkg::MODE_PAR |=> serial_word_o == $past(link_word))
        else $error("serial word not taken from link");

endmodule : host_interface_mode_select

// ---- tb/host_model.sv ----
// host side model: drives the serial clock and data pins, resolves the two-wire line
// assumes the bench calls its tasks from one process; clock stands low between frames
`timescale 1ns/1ps

module host_model (
    input  wire logic        two_wire_i,
    input  wire logic        sdo_i,
    input  wire logic        sda_out_i,
    input  wire logic        sda_oe_n_i,
    output logic             clk_pin_o,
    output logic             data_pin_o
);
    logic        host_bit_r;   // level the host drives, or releases in two-wire mode
    logic [23:0] rb_bits;      // readback gathered msb first
    int          ack_bad;      // acknowledge slots seen wrong

    // pull-up line in two-wire mode: either party may only pull low
    assign data_pin_o = two_wire_i ? (host_bit_r & (sda_oe_n_i | sda_out_i)) : host_bit_r;

    initial begin
        clk_pin_o  = 1'b0;
        host_bit_r = 1'b0;
        rb_bits    = '0;
        ack_bad    = 0;
    end

    // shift-mode bit: data moves after the rise and is stable over the fall
    task automatic spi_bit(input logic b);
        #3 clk_pin_o = 1'b1;
        #1 host_bit_r = b;
        #5 rb_bits = {rb_bits[22:0], sdo_i};
        clk_pin_o = 1'b0;
        #3;
    endtask : spi_bit

    // shift-mode word msb first, after pre uncounted clocks
    task automatic spi_word(input logic [23:0] w, input int pre);
        for (int i = 0; i < pre; i++) spi_bit(1'b0);
        for (int i = 23; i >= 0; i--) spi_bit(w[i]);
        host_bit_r = ~host_bit_r;  // line no longer carries meaning
    endtask : spi_word

    // two-wire bit: data set while the clock is low
    task automatic i2c_bit(input logic b);
        host_bit_r = b;
        #3 clk_pin_o = 1'b1;
        #6 clk_pin_o = 1'b0;
        #3;
    endtask : i2c_bit

    // two-wire word of three bytes, acknowledge slot after each byte
    task automatic i2c_word(input logic [23:0] w, input int pre);
        for (int i = 0; i < pre; i++) i2c_bit(1'b1);
        for (int k = 2; k >= 0; k--) begin
            for (int i = 7; i >= 0; i--) i2c_bit(w[k*8+i]);
            host_bit_r = 1'b1;
            #3 clk_pin_o = 1'b1;
            if (sda_oe_n_i !== 1'b0 || data_pin_o !== 1'b0) ack_bad++;
            #6 clk_pin_o = 1'b0;
            #1 if (sda_oe_n_i !== 1'b1) ack_bad++;
            #2;
        end
    endtask : i2c_word
endmodule : host_model

// ---- tb/host_interface_mode_select_test.sv ----
// self-checking bench for the host interface mode select block
// assumes host_model drives the serial pins; all other pins driven here
`timescale 1ns/1ps

module host_interface_mode_select_test;
    localparam int WB = 24;
    logic          clk_i, rst_n_i, pd, sel, mode_pin, ten_pin, strap, gnd_load;
    logic          clear_n, hw_n, clk12, din;
    logic [WB-1:0] rb_word, w;
    logic [31:0]   v;
    int            err_count, cmp_count;
    host_if_pkg::host_mode_t mode_o;
    logic          fifo_o, lp_o, hiz_o, gnd_o, valid_o, sdo_o, sdo_oe_n_o, sda_o, sda_oe_n;
    logic [2:0]    par_o;
    logic [WB-1:0] word_o;

    // system clock
    initial clk_i = 1'b0;
    always #10 clk_i = ~clk_i;

    host_model host_u (
        .two_wire_i (sel & mode_pin),
        .sdo_i      (sdo_o),
        .sda_out_i  (sda_o),
        .sda_oe_n_i (sda_oe_n),
        .clk_pin_o  (clk12),
        .data_pin_o (din)
    );

    host_interface_mode_select #(.WORD_BITS(WB)) dut_u (
        .clk_i                       (clk_i),
        .rst_n_i                     (rst_n_i),
        .data_bit_twelve_clock_pin_i (clk12),
        .power_down_input_i          (pd),
        .serial_parallel_select_i    (sel),
        .data_bit_nine_mode_pin_i    (mode_pin),
        .data_bit_ten_clock_pin_i    (ten_pin),
        .data_bit_eleven_data_pin_i  (din),
        .fifo_enable_strap_i         (strap),
        .pd_ground_load_i            (gnd_load),
        .clear_n_i                   (clear_n),
        .hw_reset_n_i                (hw_n),
        .readback_word_i             (rb_word),
        .mode_o                      (mode_o),
        .fifo_active_o               (fifo_o),
        .analog_low_power_o          (lp_o),
        .output_hiz_o                (hiz_o),
        .output_gnd_load_o           (gnd_o),
        .parallel_high_bits_o        (par_o),
        .serial_word_o               (word_o),
        .serial_word_valid_o         (valid_o),
        .serial_readback_output_o    (sdo_o),
        .serial_readback_oe_n_o      (sdo_oe_n_o),
        .sda_out_o                   (sda_o),
        .sda_oe_n_o                  (sda_oe_n)
    );

    // verdict and end of run
    task automatic close_out();
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : close_out

    // compare a single flag
    task automatic cmp_bit(input string nm, input logic e, input logic g);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s expected %b seen %b", nm, e, g);
        end
    endtask : cmp_bit

    // compare a word-wide value
    task automatic cmp_vec(input string nm, input logic [WB-1:0] e, input logic [WB-1:0] g);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp_vec

    // expected mode from the serial select and the mode pin
    function automatic host_if_pkg::host_mode_t exp_mode(input logic s, input logic m);
        if (!s) return host_if_pkg::MODE_PAR;
        return m ? host_if_pkg::MODE_I2C : host_if_pkg::MODE_SPI;
    endfunction : exp_mode

    // let synchronised pins reach the outputs
    task automatic settle();
        repeat (5) @(posedge clk_i);
        @(negedge clk_i);
    endtask : settle

    // falling-edge event on clear (c=1) or hardware reset (c=0)
    task automatic pulse_event(input logic c);
        @(posedge clk_i);
        if (c) clear_n <= 1'b0;
        else hw_n <= 1'b0;
        repeat (2) @(posedge clk_i);
        clear_n <= 1'b1;
        hw_n    <= 1'b1;
        settle();
    endtask : pulse_event

    // restart in a new mode with pins static before release
    task automatic go_mode(input logic s, input logic m);
        @(posedge clk_i);
        rst_n_i  <= 1'b0;
        sel      <= s;
        mode_pin <= m;
        strap    <= 1'b0;
        repeat (3) @(posedge clk_i);
        rst_n_i <= 1'b1;
        settle();
    endtask : go_mode

    // bounded wait for the word pulse, then check it lasts one cycle
    task automatic wait_valid();
        for (int i = 0; i < 40; i++) begin
            @(negedge clk_i);
            if (valid_o === 1'b1) begin
                @(negedge clk_i);
                cmp_bit("valid_pulse", 1'b0, valid_o);
                return;
            end
        end
        err_count++;
        $display("BAD valid_wait expected 1 seen 0");
        close_out();
    endtask : wait_valid

    initial begin
        {rst_n_i, pd, sel, mode_pin, ten_pin, gnd_load} = '0;
        {strap, clear_n, hw_n} = 3'h7;
        rb_word   = '0;
        err_count = 0;
        cmp_count = 0;
        void'($urandom(32'h8A1567C4));
        repeat (10) @(posedge clk_i);
        rst_n_i <= 1'b1;
        settle();
        cmp_bit("fifo_powerup", 1'b1, fifo_o);
        cmp_vec("mode_par", WB'(exp_mode(1'b0, 1'b0)), WB'(mode_o));
        // parallel mode: shared pins are the top data bits
        for (int i = 0; i < 8; i++) begin
            v = $urandom;
            @(posedge clk_i);
            mode_pin <= v[0];
            ten_pin  <= v[1];
            host_u.host_bit_r <= v[2];
            settle();
            cmp_vec("par_bits", WB'(v[2:0]), WB'(par_o));
        end
        // strap held between events, re-sampled at clear and reset
        strap <= 1'b0;
        settle();
        cmp_bit("fifo_hold", 1'b1, fifo_o);
        pulse_event(1'b1);
        cmp_bit("fifo_clear", 1'b0, fifo_o);
        strap <= 1'b1;
        pulse_event(1'b0);
        cmp_bit("fifo_hwrst", 1'b1, fifo_o);
        // power-down in both output configurations
        for (int g = 0; g < 2; g++) begin
            @(posedge clk_i);
            pd       <= 1'b1;
            gnd_load <= g[0];
            settle();
            cmp_vec("pd_state", WB'({1'b1, ~g[0], g[0]}), WB'({lp_o, hiz_o, gnd_o}));
            pd <= 1'b0;
            settle();
            cmp_vec("pd_off", WB'(0), WB'({lp_o, hiz_o, gnd_o}));
        end
        // shift mode, words taken while powered down
        go_mode(1'b1, 1'b0);
        cmp_vec("mode_spi", WB'(exp_mode(1'b1, 1'b0)), WB'(mode_o));
        cmp_vec("par_serial", WB'(0), WB'(par_o));
        pd <= 1'b1;
        for (int k = 0; k < 3; k++) begin
            w       = WB'($urandom);
            rb_word = (k == 1) ? '1 : WB'($urandom);
            // one uncounted clock lets the link resynchronise the mode pins
            host_u.spi_word(w, (k == 0) ? 1 : 0);
            wait_valid();
            cmp_vec("spi_word", w, word_o);
            cmp_vec("readback", rb_word, host_u.rb_bits);
            cmp_bit("pd_spi", 1'b1, lp_o);
            cmp_bit("sdo_oe_spi", 1'b0, sdo_oe_n_o);
        end
        // strap high in serial mode never enables the fifo
        strap <= 1'b1;
        pulse_event(1'b1);
        cmp_bit("fifo_serial", 1'b0, fifo_o);
        strap <= 1'b0;
        // two-wire mode with acknowledge after each byte
        go_mode(1'b1, 1'b1);
        cmp_vec("mode_i2c", WB'(exp_mode(1'b1, 1'b1)), WB'(mode_o));
        w = WB'($urandom);
        host_u.i2c_word(w, 1);
        wait_valid();
        cmp_vec("i2c_word", w, word_o);
        cmp_bit("ack_slots", 1'b1, host_u.ack_bad == 0);
        cmp_bit("sda_low_only", 1'b0, sda_o);
        cmp_bit("sdo_oe_i2c", 1'b1, sdo_oe_n_o);
        close_out();
    end
endmodule : host_interface_mode_select_test
